// [bench/txcpa_host_model.sv]
`timescale 1ns/10ps
// Host logic: a counting character stream on its own 15 ns clock.
module txcpa_host_model (
    input wire logic run_i, // Clock runs while high.
    output logic clk_o, // Host transmit clock.
    output logic [7:0] char_o, // Character, low count bits.
    output logic [1:0] ctrl_o // Control bits, high count bits.
);
    // Stands low when stopped, as the pin's pull-down would hold it.
    // It runs faster than the character clock, so the buffer overruns on purpose.
    initial clk_o = 1'b0;
    always begin
        #7.5;
        clk_o = run_i ? ~clk_o : 1'b0;
    end
    // One new character after every rising edge, changed just after it.
    initial {ctrl_o, char_o} = 10'h000;
    always @(posedge clk_o) begin
        #1 {ctrl_o, char_o} <= {ctrl_o, char_o} + 10'h001;
    end
endmodule : txcpa_host_model

// [bench/txcpa_tb_top.sv]
`timescale 1ns/10ps
// Self-checking bench: bypass, half rate, clock rates, host mode errors.
module txcpa_tb_top
    import txcpa_pkg::*;
;
    logic clk_i, rst_b_i, host_run, host_clk, word_sync, enc_ready, err, clko, centered;
    logic [7:0] host_char, tb_char;
    logic [1:0] host_ctrl, tb_ctrl;
    txcpa_cfg_type cfg;
    txcpa_word_type word;
    int errors, n_checks, k, r, rises;
    logic [9:0] prev;
    // Pins carry the host stream in host mode, bench values otherwise.
    txcpa_host_model txcpa_host_model_i (.run_i(host_run), .clk_o(host_clk),
        .char_o(host_char), .ctrl_o(host_ctrl));
    txcpa_top txcpa_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .host_tx_in_clk_i(host_clk),
        .tx_char_in_i(cfg.tx_clk_select ? tb_char : host_char),
        .tx_ctrl_in_i(cfg.tx_clk_select ? tb_ctrl : host_ctrl), .cfg_i(cfg),
        .word_sync_i(word_sync), .enc_ready_i(enc_ready), .tx_word_o(word),
        .tx_path_error_o(err), .tx_clk_out_o(clko), .phase_buf_centered_o(centered));
    // 50 MHz character clock.
    initial clk_i = 1'b0;
    always #10 clk_i = ~clk_i;
    // Compares and counts; a mismatch is reported at once.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Inputs always change 1 ns after the rising edge.
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    // Rising edges of the clock output over 16 cycles.
    function automatic logic [19:0] rises_exp(input logic rate);
        return rate ? 20'h00008 : 20'h00004;
    endfunction : rises_exp
    // A recenter request is a low pulse on the latch.
    task automatic recenter();
        cfg.recenter_n = 1'b0;
        step(4);
        cfg.recenter_n = RECENTER_IDLE;
    endtask : recenter
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    // Watchdog well past the expected run length.
    initial begin
        #400us;
        errors++;
        results();
    end
    initial begin
        errors = 0;
        n_checks = 0;
        cfg = '{1'b1, 1'b0, 1'b0, RECENTER_IDLE};
        {word_sync, enc_ready, tb_char, tb_ctrl, host_run, rst_b_i} = {12'h600, 2'h2};
        void'($urandom(33969));
        step(5);
        check("reset outputs", {word, err, clko, centered}, 20'h00000);
        step(1);
        rst_b_i = 1'b1;
        host_run = 1'b0;
        // Reference capture with the buffer bypassed, two edges of latency.
        step(4);
        for (k = 0; k < 40; k++) begin
            prev = {tb_ctrl, tb_char};
            {tb_ctrl, tb_char} = 10'($urandom);
            step(1);
            check("bypass word", {word.valid, word.pair, word.rise}, {2'h2, prev});
        end
        // Half rate pairs two samples; random encoder stalls.
        cfg.half_rate = 1'b1;
        // Ready is forced for six cycles so that a paired word is loaded before the checks.
        for (k = 0; k < 40; k++) begin
            prev = {tb_ctrl, tb_char};
            {enc_ready, tb_ctrl, tb_char} = 11'($urandom) | {(k < 6), 10'h000};
            step(1);
            if (k > 5) check("pair flag", word.pair, 20'h00001);
            if (k > 5 && enc_ready) check("both lanes", {word.fall, word.rise}, {tb_ctrl, tb_char, prev});
        end
        $display("test bypass done");
        cfg.half_rate = 1'b0;
        enc_ready = 1'b1;
        for (r = 0; r < 2; r++) begin
            cfg.tx_rate_select = r[0];
            step(8);
            rises = 0;
            for (k = 0; k < 16; k++) begin
                prev[0] = clko;
                step(1);
                rises += int'(clko && !prev[0]);
            end
            check("clock out rises", rises[19:0], rises_exp(r[0]));
        end
        $display("test clock rate done");
        // Host mode: fill, run, then overrun because the host runs fast.
        cfg.tx_clk_select = 1'b0;
        host_run = 1'b1;
        recenter();
        for (k = 0; k < 300 && centered !== 1'b1; k++) step(1);
        check("centered", centered, 20'h00001);
        check("error after fill", err, 20'h00000);
        prev = word.rise;
        for (k = 0; k < 6; k++) begin
            step(1);
            check("host order", word.rise, prev + 10'h001);
            prev = word.rise;
        end
        for (k = 0; k < 400 && err !== 1'b1; k++) step(1);
        check("overrun error", err, 20'h00001);
        host_run = 1'b0;
        enc_ready = 1'b0;
        step(10);
        check("error held", err, 20'h00001);
        word_sync = 1'b1;
        step(1);
        word_sync = 1'b0;
        step(2);
        check("error after sync", err, 20'h00000);
        // With the host stopped the reader drains the buffer and must underflow.
        enc_ready = 1'b1;
        for (k = 0; k < 100 && err !== 1'b1; k++) step(1);
        check("underflow error", err, 20'h00001);
        $display("test host error done");
        host_run = 1'b1;
        enc_ready = 1'b1;
        for (k = 0; k < 400 && err !== 1'b1; k++) step(1);
        recenter();
        for (k = 0; k < 10 && centered !== 1'b0; k++) step(1);
        check("recenter drop", centered, 20'h00000);
        for (k = 0; k < 300 && centered !== 1'b1; k++) step(1);
        check("error after recenter", {centered, err}, 20'h00002);
        $display("test recenter done");
        results();
    end
endmodule : txcpa_tb_top

// [bench/txcpa_tx_monitor.sv]
`timescale 1ns/10ps
// Port-level checker for the transmit clocking and phase-align block.
module txcpa_tx_monitor
    import txcpa_pkg::*;
(
    input wire logic clk_i, // Character clock.
    input wire logic rst_b_i, // Reset, active low.
    input wire logic host_tx_in_clk_i, // Host clock, not used here.
    input wire logic [CHAR_W-1:0] tx_char_in_i, // Host character.
    input wire logic [CTRL_W-1:0] tx_ctrl_in_i, // Host control bits.
    input wire txcpa_cfg_type cfg_i, // Configuration latches.
    input wire logic word_sync_i, // Word sync sent.
    input wire logic enc_ready_i, // Encoder ready.
    input wire txcpa_word_type tx_word_o, // Word toward encoder.
    input wire logic tx_path_error_o, // Sticky error.
    input wire logic tx_clk_out_o, // Clock output.
    input wire logic phase_buf_centered_o // Buffer running.
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // Four quiet cycles let the configuration pass its synchroniser.
    sequence s_cfg_steady;
        $stable(cfg_i) [*4];
    endsequence
    // A recenter request while the buffer runs in host mode.
    sequence s_recenter;
        $fell(cfg_i.recenter_n) ##0 phase_buf_centered_o ##0 !cfg_i.tx_clk_select;
    endsequence
    a_rate_double: assert property (s_cfg_steady ##0 cfg_i.tx_rate_select
        |-> tx_clk_out_o != $past(tx_clk_out_o)) else $error("clock out not at half rate");
    a_rate_single: assert property (s_cfg_steady ##0 !cfg_i.tx_rate_select ##0
        $rose(tx_clk_out_o) |=> tx_clk_out_o ##1 !tx_clk_out_o) else $error("clock out high time");
    a_stall_hold: assert property (s_cfg_steady ##0 tx_word_o.valid && !enc_ready_i
        |=> $stable(tx_word_o)) else $error("word changed while stalled");
    a_bypass_lat: assert property (s_cfg_steady ##0 cfg_i.tx_clk_select && !cfg_i.half_rate
        && enc_ready_i && $past(enc_ready_i) && $past(enc_ready_i, 2) |-> tx_word_o.valid
        && tx_word_o.rise == $past({tx_ctrl_in_i, tx_char_in_i}, 2)) else $error("bypass data");
    a_pair_half: assert property (s_cfg_steady ##0 cfg_i.tx_clk_select && cfg_i.half_rate
        && $past(enc_ready_i) |-> tx_word_o.pair && tx_word_o.valid)
        else $error("half rate word not paired");
    a_host_single: assert property (s_cfg_steady ##0 !cfg_i.tx_clk_select
        |-> !tx_word_o.pair) else $error("host mode word paired");
    a_bypass_idle: assert property (s_cfg_steady ##0 cfg_i.tx_clk_select
        |-> !phase_buf_centered_o) else $error("buffer running in bypass");
    a_err_clear: assert property ($fell(tx_path_error_o) |-> $past(word_sync_i)
        or ##[0:2] $rose(phase_buf_centered_o)) else $error("error cleared without cause");
    a_recenter_drop: assert property (s_recenter |-> ##[2:6] !phase_buf_centered_o)
        else $error("recenter ignored");
endmodule : txcpa_tx_monitor

bind txcpa_top txcpa_tx_monitor txcpa_tx_monitor_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .host_tx_in_clk_i(host_tx_in_clk_i), .tx_char_in_i(tx_char_in_i),
    .tx_ctrl_in_i(tx_ctrl_in_i), .cfg_i(cfg_i), .word_sync_i(word_sync_i),
    .enc_ready_i(enc_ready_i), .tx_word_o(tx_word_o), .tx_path_error_o(tx_path_error_o),
    .tx_clk_out_o(tx_clk_out_o), .phase_buf_centered_o(phase_buf_centered_o));

// [hw/txcpa_pkg.sv]
// Shared constants and carriers for the transmit clocking and phase-align block.
package txcpa_pkg;

    // Width of one host character and its control field.
    localparam int CHAR_W = 8;
    localparam int CTRL_W = 2;

    // Phase-align buffer geometry; the center mark is half the depth.
    localparam int PA_DEPTH = 32;
    localparam int PA_AW = 5;
    localparam logic [PA_AW:0] PA_CENTER = 6'h10;

    // Transmit clock output divider limits, in clk_i cycles per half period minus one.
    localparam logic CLKO_LIM_SINGLE = 1'h1;
    localparam logic CLKO_LIM_DOUBLE = 1'h0;

    // Reset value of the recenter latch: idle high, a write of 0 requests a recenter.
    localparam logic RECENTER_IDLE = 1'h1;

    // One host character with its control bits.
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [CHAR_W-1:0] data;
    } txcpa_char_type;

    // Word handed to the encoder: rise lane always, fall lane only in half-rate pairs.
    typedef struct packed {
        logic valid;
        logic pair;
        txcpa_char_type fall;
        txcpa_char_type rise;
    } txcpa_word_type;

    // Static configuration latches, synchronised as one group.
    typedef struct packed {
        logic tx_clk_select;
        logic half_rate;
        logic tx_rate_select;
        logic recenter_n;
    } txcpa_cfg_type;

    // Phase-align state machine, one-hot.
    typedef enum logic [2:0] {
        PA_BYPASS = 3'h1,
        PA_FILL = 3'h2,
        PA_RUN = 3'h4
    } txcpa_state_type;

endpackage : txcpa_pkg

// [hw/txcpa_top.sv]
// Function
// [R1] Reference clock times transmit and receive PLLs.
// [R2] Reference clock selectable as parallel interface clock.
// [R3] Select 0: capture inputs on host clock.
// [R4] Host clock matches output frequency, any phase.
// [R5] Tolerate host drift of plus/minus 180 degrees.
// [R6] Buffer overrun or underrun raises sticky error.
// [R7] Writing recenter latch 0 recenters buffer.
// [R8] Error clears only once buffer is initialized. The code also clears it on a word sync, as in [R14].
// [R9] Half-rate reference: sample inputs on both edges.
// [R10] Half-rate reference: present outputs for both edges.
// [R11] Transmit clock output follows character clock.
// [R12] Output clock single or double rate by select.
// [R13] No fixed phase to reference clock.
// [R14] Word sync transmission also clears error.
// [R15] Select 1: capture on reference, bypass buffer.
`timescale 1ns/10ps

// Dual-clock phase-align buffer with gray pointers crossing between the two sides.
module txcpa_pa_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic wr_clk_i, // Write side clock.
    input wire logic wr_rst_b_i, // Write side reset, active low.
    input wire logic wr_valid_i, // Write request.
    output logic wr_ready_o, // Room for one more word.
    input wire logic [WIDTH-1:0] wr_data_i, // Write data.
    input wire logic rd_clk_i, // Read side clock.
    input wire logic rd_rst_b_i, // Read side reset, active low.
    input wire logic rd_flush_i, // Jump read pointer onto write pointer.
    output logic rd_valid_o, // Word available.
    input wire logic rd_ready_i, // Read request.
    output logic [WIDTH-1:0] rd_data_o, // Word at the read pointer.
    output logic [AW:0] rd_level_o // Words held, as seen from the read side.
);
    logic [WIDTH-1:0] mem_q [DEPTH]; // Storage flops, addressed by pointer.
    logic [AW:0] wr_bin_q, wr_bin_d, wr_gray_q, wr_gray_d; // Write pointer.
    logic [AW:0] rd_bin_q, rd_bin_d, rd_gray_q, rd_gray_d; // Read pointer.
    logic [AW:0] rg_meta_q, rg_sync_q; // Read pointer seen by the writer.
    logic [AW:0] wg_meta_q, wg_sync_q; // Write pointer seen by the reader.
    logic [AW:0] wr_seen_bin; // Synchronised write pointer in binary.
    logic push, pop; // Accepted transfers.

    // Converts a gray pointer back to binary.
    function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

    // Write side next values; full compares against the inverted top bits.
    always_comb begin
        wr_ready_o = (wr_gray_q != {~rg_sync_q[AW:AW-1], rg_sync_q[AW-2:0]});
        push = wr_valid_i && wr_ready_o;
        wr_bin_d = wr_bin_q + {{AW{1'b0}}, push};
        wr_gray_d = wr_bin_d ^ (wr_bin_d >> 1);
    end

    // Write side registers, including the two-flop read pointer synchroniser.
    always_ff @(posedge wr_clk_i or negedge wr_rst_b_i) begin
        if (!wr_rst_b_i) begin
            wr_bin_q <= '0;
            wr_gray_q <= '0;
            rg_meta_q <= '0;
            rg_sync_q <= '0;
        end else begin
            wr_bin_q <= wr_bin_d;
            wr_gray_q <= wr_gray_d;
            rg_meta_q <= rd_gray_q;
            rg_sync_q <= rg_meta_q;
        end
    end

    // Storage needs no reset; only written words are ever read.
    always_ff @(posedge wr_clk_i) begin
        if (push) begin
            mem_q[wr_bin_q[AW-1:0]] <= wr_data_i;
        end
    end

    // Read side next values; a flush discards every word the reader sees but has not taken.
    always_comb begin
        wr_seen_bin = gray2bin(wg_sync_q);
        rd_valid_o = (rd_gray_q != wg_sync_q);
        rd_data_o = mem_q[rd_bin_q[AW-1:0]];
        rd_level_o = wr_seen_bin - rd_bin_q;
        pop = rd_valid_o && rd_ready_i;
        if (rd_flush_i) begin
            rd_bin_d = wr_seen_bin;
        end else begin
            rd_bin_d = rd_bin_q + {{AW{1'b0}}, pop};
        end
        rd_gray_d = rd_bin_d ^ (rd_bin_d >> 1);
    end

    // Read side registers, including the two-flop write pointer synchroniser.
    always_ff @(posedge rd_clk_i or negedge rd_rst_b_i) begin
        if (!rd_rst_b_i) begin
            rd_bin_q <= '0;
            rd_gray_q <= '0;
            wg_meta_q <= '0;
            wg_sync_q <= '0;
        end else begin
            rd_bin_q <= rd_bin_d;
            rd_gray_q <= rd_gray_d;
            wg_meta_q <= wr_gray_q;
            wg_sync_q <= wg_meta_q;
        end
    end
endmodule : txcpa_pa_fifo

// Transmit clocking for one channel: input capture, phase-align buffer, clock output.
module txcpa_top
    import txcpa_pkg::*;
(
    input wire logic clk_i, // Internal character clock, locked to the reference.
    input wire logic rst_b_i, // Asynchronous reset, active low.
    input wire logic host_tx_in_clk_i, // Host transmit input clock.
    input wire logic [CHAR_W-1:0] tx_char_in_i, // Host character.
    input wire logic [CTRL_W-1:0] tx_ctrl_in_i, // Host control bits.
    input wire txcpa_cfg_type cfg_i, // Configuration latches.
    input wire logic word_sync_i, // Pulse: a word sync sequence went out.
    input wire logic enc_ready_i, // Encoder takes the current word.
    output txcpa_word_type tx_word_o, // Word toward the encoder.
    output logic tx_path_error_o, // Sticky buffer error, high active.
    output logic tx_clk_out_o, // Transmit clock output.
    output logic phase_buf_centered_o // Buffer initialized and running.
);
    // Host clock domain.
    logic hrst_meta_q, hrst_b_q; // Reset release synchroniser for the host side.
    logic hsel_meta_q, hsel_q; // Clock select seen on the host side.
    txcpa_char_type hcap_q, hcap_d; // Input register on the host clock.
    logic hcap_vld_q, hcap_vld_d; // Input register holds a host character.
    logic ovf_tgl_q, ovf_tgl_d; // Flips on every lost host character.
    logic fifo_wr_ready; // Buffer has room.

    // Reference clock domain.
    txcpa_cfg_type cfg_meta_q, cfg_q; // Synchronised configuration.
    logic rcn_prev_q; // Previous recenter latch value.
    logic ovf_meta_q, ovf_s_q, ovf_s2_q; // Overflow toggle crossing.
    txcpa_char_type rise_q, fall_q; // Reference-clock captures of the inputs.
    txcpa_state_type state_q, state_d; // Phase-align state.
    txcpa_word_type word_q, word_d; // Output word register.
    logic err_q, err_d; // Transmit path error.
    logic cent_q, cent_d; // Centered indication.
    logic clko_q, clko_d, clko_cnt_q, clko_cnt_d; // Clock output divider.
    logic recenter_evt, ovf_evt, flush, take, underflow, clko_lim; // Decoded events.
    logic fifo_rd_valid; // Buffer not empty.
    txcpa_char_type fifo_rd_data; // Word at the buffer head.
    logic [PA_AW:0] fifo_level; // Buffer fill level.

    // Host reset is asserted at once but released on the host clock.
    always_ff @(posedge host_tx_in_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hrst_meta_q <= 1'h0;
            hrst_b_q <= 1'h0;
        end else begin
            hrst_meta_q <= 1'h1;
            hrst_b_q <= hrst_meta_q;
        end
    end

    // Host input register; it is loaded on every rising host clock edge but marked valid only in host clock mode.
    always_comb begin
        hcap_d = '{ctrl: tx_ctrl_in_i, data: tx_char_in_i}; // [R3]
        hcap_vld_d = !hsel_q; // [R3]
        ovf_tgl_d = ovf_tgl_q ^ (hcap_vld_q && !fifo_wr_ready); // [R6]
    end

    // Host side registers; the host clock may stop, so nothing here must finish later.
    always_ff @(posedge host_tx_in_clk_i or negedge hrst_b_q) begin
        if (!hrst_b_q) begin
            hsel_meta_q <= 1'h1;
            hsel_q <= 1'h1;
            hcap_q <= '0;
            hcap_vld_q <= 1'h0;
            ovf_tgl_q <= 1'h0;
        end else begin
            hsel_meta_q <= cfg_i.tx_clk_select;
            hsel_q <= hsel_meta_q;
            hcap_q <= hcap_d;
            hcap_vld_q <= hcap_vld_d;
            ovf_tgl_q <= ovf_tgl_d;
        end
    end

    // The buffer absorbs the unknown and drifting phase of the host clock.
    txcpa_pa_fifo #(
        .WIDTH(CHAR_W + CTRL_W),
        .DEPTH(PA_DEPTH),
        .AW(PA_AW)
    ) u_pa_fifo (
        .wr_clk_i(host_tx_in_clk_i),
        .wr_rst_b_i(hrst_b_q),
        .wr_valid_i(hcap_vld_q),
        .wr_ready_o(fifo_wr_ready),
        .wr_data_i(hcap_q),
        .rd_clk_i(clk_i),
        .rd_rst_b_i(rst_b_i),
        .rd_flush_i(flush),
        .rd_valid_o(fifo_rd_valid),
        .rd_ready_i(take),
        .rd_data_o(fifo_rd_data),
        .rd_level_o(fifo_level)
    ); // [R4] [R5]

    // Inputs in reference clock mode are sampled on the rising edge.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rise_q <= '0;
        end else begin
            rise_q <= '{ctrl: tx_ctrl_in_i, data: tx_char_in_i}; // [R2] [R15]
        end
    end

    // In half-rate operation the falling edge carries the second character.
    always_ff @(negedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fall_q <= '0;
        end else begin
            fall_q <= '{ctrl: tx_ctrl_in_i, data: tx_char_in_i}; // [R9]
        end
    end

    // State, output word, error flag and clock divider, all on the reference clock.
    always_comb begin
        recenter_evt = rcn_prev_q && !cfg_q.recenter_n; // [R7]
        ovf_evt = ovf_s_q ^ ovf_s2_q;
        // A flush discards stale words, leaving the writer to refill to center.
        flush = (state_q != PA_FILL) && !cfg_q.tx_clk_select; // [R7]
        flush = flush && ((state_q == PA_BYPASS) || recenter_evt); // [R7]
        take = (state_q == PA_RUN) && (!word_q.valid || enc_ready_i) && !recenter_evt;
        underflow = take && !fifo_rd_valid; // [R6]
        state_d = state_q;
        word_d = word_q;
        cent_d = 1'h0;
        err_d = err_q;
        case (state_q)
            PA_BYPASS: begin
                if (!cfg_q.tx_clk_select) begin
                    state_d = PA_FILL;
                end
            end
            PA_FILL: begin
                if (cfg_q.tx_clk_select) begin
                    state_d = PA_BYPASS;
                end else if (fifo_level >= PA_CENTER) begin
                    state_d = PA_RUN;
                    err_d = 1'h0; // [R8]
                end
            end
            PA_RUN: begin
                cent_d = 1'h1;
                if (cfg_q.tx_clk_select) begin
                    state_d = PA_BYPASS;
                end else if (recenter_evt) begin
                    state_d = PA_FILL; // [R7]
                end
            end
            default: begin
                state_d = PA_BYPASS;
            end
        endcase
        // A word sync clears the error even without a recenter.
        if (word_sync_i) begin
            err_d = 1'h0; // [R14]
        end
        // Set wins over every clear so that no fault slips by unseen.
        if ((ovf_evt || underflow) && (state_q != PA_BYPASS)) begin
            err_d = 1'h1; // [R6]
        end
        // The output word advances only when the encoder takes the current one or no valid word is held.
        if (!word_q.valid || enc_ready_i) begin
            if (state_q == PA_BYPASS) begin
                word_d.valid = 1'h1; // [R15]
                word_d.pair = cfg_q.half_rate; // [R10]
                word_d.rise = rise_q;
                word_d.fall = cfg_q.half_rate ? fall_q : '0; // [R9] [R10]
            end else begin
                word_d.valid = take && fifo_rd_valid; // [R3]
                word_d.pair = 1'h0;
                word_d.rise = fifo_rd_data;
                word_d.fall = '0;
            end
        end
        // The divider gives the single or double rate output from the character clock.
        clko_lim = cfg_q.tx_rate_select ? CLKO_LIM_DOUBLE : CLKO_LIM_SINGLE; // [R12]
        clko_cnt_d = (clko_cnt_q == clko_lim) ? 1'h0 : ~clko_cnt_q;
        clko_d = (clko_cnt_q == clko_lim) ? ~clko_q : clko_q; // [R11]
    end

    // Reference clock registers. The config and toggle synchronisers use two flops.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_meta_q <= '{tx_clk_select: 1'h1, half_rate: 1'h0,
                            tx_rate_select: 1'h0, recenter_n: RECENTER_IDLE};
            cfg_q <= '{tx_clk_select: 1'h1, half_rate: 1'h0,
                       tx_rate_select: 1'h0, recenter_n: RECENTER_IDLE};
            rcn_prev_q <= RECENTER_IDLE;
            ovf_meta_q <= 1'h0;
            ovf_s_q <= 1'h0;
            ovf_s2_q <= 1'h0;
            state_q <= PA_BYPASS;
            word_q <= '0;
            err_q <= 1'h0;
            cent_q <= 1'h0;
            clko_q <= 1'h0;
            clko_cnt_q <= 1'h0;
        end else begin
            cfg_meta_q <= cfg_i;
            cfg_q <= cfg_meta_q;
            rcn_prev_q <= cfg_q.recenter_n;
            ovf_meta_q <= ovf_tgl_q;
            ovf_s_q <= ovf_meta_q;
            ovf_s2_q <= ovf_s_q;
            state_q <= state_d;
            word_q <= word_d;
            err_q <= err_d;
            cent_q <= cent_d;
            clko_q <= clko_d;
            clko_cnt_q <= clko_cnt_d;
        end
    end

    // The clock output is a plain divider flop; its phase to the reference is not fixed.
    assign tx_clk_out_o = clko_q; // [R1] [R13]
    assign tx_word_o = word_q;
    assign tx_path_error_o = err_q;
    assign phase_buf_centered_o = cent_q;

endmodule : txcpa_top
